// [core/psbc_regs.vh]
// constants for the processor sideband control block
// assumes it is included by bare name from core design files
`ifndef PSBC_REGS_VH
`define PSBC_REGS_VH

// ==================================================================
// timing
`define PSBC_CLK_PERIOD_NS   5
`define PSBC_RESET_RELEASE_CLKS 2
`define PSBC_SYNC_STAGES     2

// ==================================================================
// power-on configuration capture
`define PSBC_CFG_WIDTH       8
`define PSBC_CFG_RESET       8'h00

// ==================================================================
// sequencer states
`define PSBC_ST_RUN          3'h0
`define PSBC_ST_INIT         3'h1
`define PSBC_ST_SHUT         3'h2
`define PSBC_ST_BUILTIN_SELF_TEST         3'h3
`define PSBC_ST_HALT         3'h4

// ==================================================================
// bus transaction type codes driven on o_bus_req_type
`define PSBC_TXN_NONE        2'h0
`define PSBC_TXN_A           2'h1
`define PSBC_TXN_LOCKED      2'h2

`endif

// [core/psbc_sync.v]
// parameterised multi-stage synchroniser for asynchronous inputs
// assumes the destination domain is i_clock
`timescale 1ns/100ps
module psbc_sync #(
  parameter WIDTH  = 1,
  parameter STAGES = 2
) (
  input  wire             i_clock,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage_r [0:STAGES-1];
  integer k;

  // first stage feeds only the next stage
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (k = 0; k < STAGES; k = k + 1) begin
        stage_r[k] <= {WIDTH{1'b0}};
      end
    end else begin
      stage_r[0] <= i_async;
      for (k = 1; k < STAGES; k = k + 1) begin
        stage_r[k] <= stage_r[k-1];
      end
    end
  end

  assign o_sync = stage_r[STAGES-1];
endmodule

// [core/psbc_cfg_store.v]
// small register store holding power-on configuration and reset vector
// assumes capture strobe is one cycle wide, in the i_clock domain
`timescale 1ns/100ps
module psbc_cfg_store #(
  parameter WIDTH = 8
) (
  input  wire             i_clock,
  input  wire             i_rst,
  input  wire             i_capture,
  input  wire [WIDTH-1:0] i_data,
  output reg  [WIDTH-1:0] o_data
);
  // capture is clocked, never taken by the asynchronous reset
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_data <= {WIDTH{1'b0}};
    end else if (i_capture) begin
      o_data <= i_data;
    end
  end
endmodule

// [core/psbc_top.v]
// processor sideband control: internal error, numeric error ignore,
// soft init, local interrupt fallback and bus lock indication
// assumes core events arrive synchronous to i_clock; sideband pins async
//
// Notes on behaviour
// - internal error output asserts on error and holds until hard reset
// - internal error also issues one transaction_a transaction on the bus
// - ignore input asserted: pending numeric error is disregarded
// - ignore input deasserted: pending error raises exception on next fp op
// - ignore input has no effect while numeric error enable bit set
// - soft init resets integer registers, keeps caches and fp registers
// - after soft init execution restarts at configured reset vector
// - snoop requests keep being serviced while soft init asserted
// - soft init input is synchronised before use
// - soft init active at reset release selects built-in self-test
// - controller disabled: input 0 is maskable, input 1 is nonmaskable
// - local interrupt controller enabled after reset
// - both local interrupt inputs synchronised before use
// - atomic lock held from start of first to end of last locked txn
// - configuration bus signals captured at reset release
// - bus outputs released within two clocks of hard reset
`timescale 1ns/100ps
`include "psbc_regs.vh"
module psbc_top #(
  parameter CFG_WIDTH = `PSBC_CFG_WIDTH
) (
  input  wire                 i_clock,
  input  wire                 i_rst,
  input  wire                 i_core_internal_error,
  input  wire                 i_ignore_numeric_error_in,
  input  wire                 i_numeric_error_enable_bit,
  input  wire                 i_fp_error_event,
  input  wire                 i_fp_noncontrol_issue,
  input  wire                 i_soft_init_in,
  input  wire [1:0]           i_local_interrupt_in,
  input  wire                 i_lic_enable_wr,
  input  wire                 i_lic_enable_val,
  input  wire                 i_snoop_req,
  input  wire                 i_lock_seq_start,
  input  wire                 i_lock_seq_last_done,
  input  wire                 i_bus_txn_ack,
  input  wire [CFG_WIDTH-1:0] i_cfg_pins,
  output reg                  o_internal_error_out,
  output reg                  o_fp_exception,
  output reg                  o_int_reg_reset,
  output reg                  o_fetch_restart,
  output reg  [CFG_WIDTH-1:0] o_reset_vector_cfg,
  output reg                  o_builtin_self_test_run,
  output reg                  o_snoop_ack,
  output reg                  o_maskable_interrupt_req,
  output reg                  o_nonmaskable_int,
  output reg  [1:0]           o_local_int_to_lic,
  output reg                  o_lic_enabled,
  output reg                  o_atomic_lock,
  output reg  [1:0]           o_bus_req_type,
  output reg                  o_bus_req_valid,
  output reg                  o_bus_drive_en
);

  // ==================================================================
  // decoders, each used within a single process
  function in_init;
    input [2:0] st;
    begin
      in_init = (st == `PSBC_ST_INIT);
    end
  endfunction

  function txn_is;
    input       valid;
    input [1:0] kind;
    input [1:0] code;
    begin
      txn_is = valid && (kind == code);
    end
  endfunction

  // ==================================================================
  // synchronisers for asynchronous sideband pins
  wire       ign_s;
  wire       init_s;
  wire [1:0] lint_s;

  psbc_sync #(.WIDTH(3), .STAGES(`PSBC_SYNC_STAGES)) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_ignore_numeric_error_in, i_local_interrupt_in}),
    .o_sync  ({ign_s, lint_s})
  );

  // soft init keeps its synchroniser running through hard reset, so the
  // level present at the release edge is already settled when sampled
  psbc_sync #(.WIDTH(1), .STAGES(`PSBC_SYNC_STAGES)) u_init_sync (
    .i_clock (i_clock),
    .i_rst   (1'b0),
    .i_async (i_soft_init_in),
    .o_sync  (init_s)
  );

  // ==================================================================
  // reset release tracking
  // the release edge is seen on the first clock after i_rst falls
  reg rst_seen_r;
  reg release_pulse_r;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rst_seen_r      <= 1'b1;
      release_pulse_r <= 1'b0;
    end else begin
      rst_seen_r      <= 1'b0;
      release_pulse_r <= rst_seen_r;
    end
  end

  wire release_now = rst_seen_r;

  // ==================================================================
  // power-on configuration capture
  wire [CFG_WIDTH-1:0] cfg_q;

  psbc_cfg_store #(.WIDTH(CFG_WIDTH)) u_cfg (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_capture (release_now),
    .i_data    (i_cfg_pins),
    .o_data    (cfg_q)
  );

  // ==================================================================
  // internal error and transaction_a request
  reg  shut_pending_r;
  // a request leaves the bus at the edge that sees it acknowledged
  wire req_accept = o_bus_req_valid && i_bus_txn_ack;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_internal_error_out <= 1'b0;
      shut_pending_r       <= 1'b0;
    end else begin
      if (i_core_internal_error) begin
        o_internal_error_out <= 1'b1;
      end
      if (i_core_internal_error && !o_internal_error_out) begin
        shut_pending_r <= 1'b1;
      end else if (shut_pending_r && req_accept &&
                   txn_is(o_bus_req_valid, o_bus_req_type, `PSBC_TXN_A)) begin
        shut_pending_r <= 1'b0;
      end
    end
  end

  // ==================================================================
  // numeric error handling
  // ignore input is sampled after sync; the two-cycle lag is the
  // reason the outside party must hold it steady around target ready
  reg  fp_err_pend_r;
  wire ignore_eff = ign_s && !i_numeric_error_enable_bit;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fp_err_pend_r  <= 1'b0;
      o_fp_exception <= 1'b0;
    end else begin
      o_fp_exception <= 1'b0;
      if (i_fp_noncontrol_issue && fp_err_pend_r && !ignore_eff) begin
        o_fp_exception <= 1'b1;
        fp_err_pend_r  <= i_fp_error_event;
      end else if (i_fp_error_event) begin
        fp_err_pend_r <= 1'b1;
      end
      // when ignored, the error stays pending but does not trap
    end
  end

  // ==================================================================
  // soft init sequencer
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg       init_d_r;
  reg       builtin_self_test_sel_r;

  wire init_rise = init_s && !init_d_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `PSBC_ST_RUN: begin
        if (init_rise) begin
          state_nxt = `PSBC_ST_INIT;
        end
      end
      `PSBC_ST_INIT: begin
        if (!init_s) begin
          state_nxt = `PSBC_ST_RUN;
        end
      end
      `PSBC_ST_BUILTIN_SELF_TEST: begin
        state_nxt = `PSBC_ST_RUN;
      end
      default: begin
        state_nxt = `PSBC_ST_RUN;
      end
    endcase
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r            <= `PSBC_ST_RUN;
      init_d_r           <= 1'b0;
      builtin_self_test_sel_r         <= 1'b0;
      o_int_reg_reset    <= 1'b0;
      o_fetch_restart    <= 1'b0;
      o_reset_vector_cfg <= `PSBC_CFG_RESET;
      o_builtin_self_test_run         <= 1'b0;
      o_snoop_ack        <= 1'b0;
    end else begin
      init_d_r <= init_s;
      if (release_now) begin
        builtin_self_test_sel_r <= init_s;
        state_r    <= init_s ? `PSBC_ST_BUILTIN_SELF_TEST : `PSBC_ST_RUN;
      end else begin
        state_r <= state_nxt;
      end
      o_builtin_self_test_run         <= release_pulse_r && builtin_self_test_sel_r;
      // the release edge overrides the sequencer, so a soft init held
      // through reset must not also pulse the integer register reset
      o_int_reg_reset    <= !release_now && in_init(state_nxt);
      o_fetch_restart    <= in_init(state_r) && !init_s;
      o_reset_vector_cfg <= cfg_q;
      o_snoop_ack        <= i_snoop_req;
    end
  end

  // ==================================================================
  // local interrupt routing
  // each pin goes either to the controller or to its fallback line
  wire [1:0] lic_route;
  wire [1:0] fallback;
  genvar     g;

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lint
      assign lic_route[g] = o_lic_enabled && lint_s[g];
      assign fallback[g]  = !o_lic_enabled && lint_s[g];
    end
  endgenerate

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_lic_enabled            <= 1'b1;
      o_maskable_interrupt_req <= 1'b0;
      o_nonmaskable_int        <= 1'b0;
      o_local_int_to_lic       <= 2'h0;
    end else begin
      if (i_lic_enable_wr) begin
        o_lic_enabled <= i_lic_enable_val;
      end
      o_maskable_interrupt_req <= fallback[0];
      o_nonmaskable_int        <= fallback[1];
      o_local_int_to_lic       <= lic_route;
    end
  end

  // ==================================================================
  // bus requests and lock
  // transaction_a takes priority over starting a new locked sequence
  reg  lock_active_r;
  // a lock start is refused while a transaction_a is still owed
  wire lock_take = i_lock_seq_start && !shut_pending_r;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lock_active_r   <= 1'b0;
      o_atomic_lock   <= 1'b0;
      o_bus_req_type  <= `PSBC_TXN_NONE;
      o_bus_req_valid <= 1'b0;
      o_bus_drive_en  <= 1'b0;
    end else begin
      o_bus_drive_en <= 1'b1;
      if (lock_take) begin
        lock_active_r <= 1'b1;
      end else if (i_lock_seq_last_done) begin
        lock_active_r <= 1'b0;
      end
      // lock held across the whole sequence so a priority agent waits
      o_atomic_lock <= (lock_active_r || lock_take) && !i_lock_seq_last_done;
      if (req_accept) begin
        o_bus_req_valid <= 1'b0;
        o_bus_req_type  <= `PSBC_TXN_NONE;
      end else if (!o_bus_req_valid && shut_pending_r) begin
        o_bus_req_valid <= 1'b1;
        o_bus_req_type  <= `PSBC_TXN_A;
      end else if (!o_bus_req_valid && i_lock_seq_start) begin
        o_bus_req_valid <= 1'b1;
        o_bus_req_type  <= `PSBC_TXN_LOCKED;
      end
    end
  end

endmodule

// [tb/psbc_props.sv]
// assertion checker on the ports of the sideband control block
// assumes it is bound onto psbc_top from the bench top file
`timescale 1ns/100ps
module psbc_props (
  input logic       i_clock,
  input logic       i_rst,
  input logic       i_core_internal_error,
  input logic       i_snoop_req,
  input logic       i_lock_seq_start,
  input logic       i_lock_seq_last_done,
  input logic       i_bus_txn_ack,
  input logic       o_internal_error_out,
  input logic       o_bus_req_valid,
  input logic [1:0] o_bus_req_type,
  input logic       o_atomic_lock,
  input logic       o_snoop_ack,
  input logic       o_lic_enabled
);
  // ==========
  // port relations
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  internal_error_out_set_a: assert property (i_core_internal_error |=> o_internal_error_out)
    else $error("error output not raised");
  internal_error_out_hold_a: assert property (o_internal_error_out |=> o_internal_error_out)
    else $error("error output dropped");
  shut_req_a: assert property ($rose(o_internal_error_out) |=>
    o_bus_req_valid && o_bus_req_type == 2'h1) else $error("no transaction_a request");
  req_hold_a: assert property (o_bus_req_valid && !i_bus_txn_ack |=>
    o_bus_req_valid && $stable(o_bus_req_type)) else $error("request not held");
  lock_rise_a: assert property ($rose(o_atomic_lock) |-> $past(i_lock_seq_start))
    else $error("lock rose without start");
  lock_end_a: assert property (o_atomic_lock && i_lock_seq_last_done |=> !o_atomic_lock)
    else $error("lock held past last transfer");
  snoop_ack_a: assert property (o_snoop_ack == $past(i_snoop_req))
    else $error("snoop not answered");
  lic_default_a: assert property ($past(i_rst) |-> o_lic_enabled)
    else $error("controller not enabled after reset");
  cover property ($rose(o_internal_error_out));
  cover property ($fell(o_atomic_lock));
  cover property (o_bus_req_valid && i_bus_txn_ack);
endmodule

// [tb/psbc_bus_agent.sv]
// far side model: bus target that accepts requests, and a priority agent
// assumes requests hold until o_ack is seen high at a rising edge
`timescale 1ns/100ps
module psbc_bus_agent (
  input  logic i_clock,
  input  logic i_rst,
  input  logic i_req_valid,
  input  logic i_atomic_lock,
  input  logic i_slow,
  input  logic i_prio_req,
  output logic o_ack,
  output logic o_prio_grant
);
  // ==========
  // answers
  logic [2:0] wait_r;
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wait_r <= 3'h0;
      o_ack <= 1'b0;
      o_prio_grant <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      // slow mode stalls so the request must stand for several cycles
      if (i_req_valid && !o_ack) begin
        wait_r <= wait_r + 3'h1;
        if (wait_r >= (i_slow ? 3'h4 : 3'h0)) begin
          o_ack <= 1'b1;
          wait_r <= 3'h0;
        end
      end
      o_prio_grant <= i_prio_req && !i_atomic_lock;
    end
  end
endmodule

// [tb/tb_psbc_top.sv]
// self-checking bench for the sideband control block
// assumes the core files and the bus agent model are compiled first
`timescale 1ns/100ps
module tb_psbc_top;
  // ==========
  // signals
  logic       i_clock = 1'b0;
  logic       i_rst   = 1'b1;
  logic       ce = 1'b0, ign = 1'b0, ne = 1'b0, fe = 1'b0, fi = 1'b0, si = 1'b0;
  logic       lw = 1'b0, lv = 1'b0, sn = 1'b0, ls = 1'b0, ld = 1'b0, slow = 1'b0, pr = 1'b0;
  logic [1:0] li = 2'h0;
  logic [7:0] cfg = 8'h00;
  wire        ack, gr, ie, fx, ir, fr, bi, sa, mi, nm, le, lk, vl, de;
  wire  [1:0] ll, rt;
  wire  [7:0] rv;
  int         errors = 0, checks = 0, cyc = 0, n_bi = 0, n_fx = 0, n_fr = 0, n_rq = 0;
  psbc_top uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_core_internal_error(ce),
    .i_ignore_numeric_error_in(ign), .i_numeric_error_enable_bit(ne),
    .i_fp_error_event(fe), .i_fp_noncontrol_issue(fi), .i_soft_init_in(si),
    .i_local_interrupt_in(li), .i_lic_enable_wr(lw), .i_lic_enable_val(lv),
    .i_snoop_req(sn), .i_lock_seq_start(ls), .i_lock_seq_last_done(ld),
    .i_bus_txn_ack(ack), .i_cfg_pins(cfg), .o_internal_error_out(ie),
    .o_fp_exception(fx), .o_int_reg_reset(ir), .o_fetch_restart(fr),
    .o_reset_vector_cfg(rv), .o_builtin_self_test_run(bi), .o_snoop_ack(sa),
    .o_maskable_interrupt_req(mi), .o_nonmaskable_int(nm), .o_local_int_to_lic(ll),
    .o_lic_enabled(le), .o_atomic_lock(lk), .o_bus_req_type(rt),
    .o_bus_req_valid(vl), .o_bus_drive_en(de));
  psbc_bus_agent agent (
    .i_clock(i_clock), .i_rst(i_rst), .i_req_valid(vl), .i_atomic_lock(lk),
    .i_slow(slow), .i_prio_req(pr), .o_ack(ack), .o_prio_grant(gr));
  // ==========
  // clock, pulse counters, hang guard
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    n_bi = n_bi + int'(bi);
    n_fx = n_fx + int'(fx);
    n_fr = n_fr + int'(fr);
    n_rq = n_rq + int'(vl && ack);
    if (cyc == 3000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // ==========
  // scenarios
  task automatic do_reset(input logic s, input logic [7:0] c);
    int b;
    @(posedge i_clock);
    i_rst <= 1'b1;
    si <= s;
    cfg <= c;
    tick(4);
    chk({ie, vl, lk, de, le}, 8'h01);
    b = n_bi;
    @(posedge i_clock);
    i_rst <= 1'b0;
    tick(4);
    chk(8'(n_bi - b), {7'h0, s});
    chk(rv, c);
    chk({6'h0, de, le}, 8'h03);
    si <= 1'b0;
    tick(8);
  endtask
  task automatic t_fp;
    int b;
    // order leaves the refused error pending so the next pass still traps
    for (int k = 0; k < 5; k++) begin
      b = n_fx;
      @(posedge i_clock);
      ign <= (k == 0 || k == 2);
      ne <= (k == 2 || k == 3);
      fe <= (k == 0 || k == 2 || k == 3);
      @(posedge i_clock);
      fe <= 1'b0;
      tick(4);
      @(posedge i_clock);
      fi <= 1'b1;
      @(posedge i_clock);
      fi <= 1'b0;
      tick(3);
      chk(8'(n_fx - b), {7'h0, k == 1 || k == 2 || k == 3});
    end
  endtask
  task automatic t_lint;
    @(posedge i_clock);
    li <= 2'h2;
    tick(4);
    chk({le, ll, mi, nm}, 8'h18);
    lw <= 1'b1;
    lv <= 1'b0;
    @(posedge i_clock);
    lw <= 1'b0;
    tick(4);
    chk({le, ll, mi, nm}, 8'h01);
    li <= 2'h1;
    tick(2);
    chk({mi, nm}, 8'h01);
    tick(2);
    chk({mi, nm}, 8'h02);
    lw <= 1'b1;
    lv <= 1'b1;
    @(posedge i_clock);
    lw <= 1'b0;
    tick(4);
    chk(le, 8'h1);
  endtask
  task automatic t_init;
    int b;
    b = n_fr;
    @(posedge i_clock);
    si <= 1'b1;
    sn <= 1'b1;
    tick(6);
    chk({ir, sa}, 8'h03);
    si <= 1'b0;
    sn <= 1'b0;
    tick(8);
    chk(8'(n_fr - b), 8'h01);
    chk({7'h0, ir}, 8'h00);
    chk(rv, 8'h5a);
  endtask
  task automatic t_lock;
    @(posedge i_clock);
    ls <= 1'b1;
    pr <= 1'b1;
    @(posedge i_clock);
    ls <= 1'b0;
    #1;
    chk({5'h0, vl, rt}, 8'h06);
    tick(3);
    chk({lk, gr}, 8'h02);
    ld <= 1'b1;
    @(posedge i_clock);
    ld <= 1'b0;
    tick(3);
    chk({lk, gr}, 8'h01);
    pr <= 1'b0;
  endtask
  task automatic t_error;
    int b;
    b = n_rq;
    @(posedge i_clock);
    slow <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      ce <= 1'b1;
      @(posedge i_clock);
      ce <= 1'b0;
      tick(12);
      chk(8'(n_rq - b), 8'h01);
      chk({6'h0, ie, vl}, 8'h02);
    end
    do_reset(1'b0, 8'h3c);
  endtask
  initial begin
    do_reset(1'b1, 8'h5a);
    t_fp;
    t_lint;
    t_init;
    t_lock;
    t_error;
    print_verdict;
  end
endmodule
bind psbc_top psbc_props u_props (
  .i_clock               (i_clock),
  .i_rst                 (i_rst),
  .i_core_internal_error (i_core_internal_error),
  .i_snoop_req           (i_snoop_req),
  .i_lock_seq_start      (i_lock_seq_start),
  .i_lock_seq_last_done  (i_lock_seq_last_done),
  .i_bus_txn_ack         (i_bus_txn_ack),
  .o_internal_error_out  (o_internal_error_out),
  .o_bus_req_valid       (o_bus_req_valid),
  .o_bus_req_type        (o_bus_req_type),
  .o_atomic_lock         (o_atomic_lock),
  .o_snoop_ack           (o_snoop_ack),
  .o_lic_enabled         (o_lic_enabled)
);
